// >>> tb/testbench.sv
// self-checking bench for the watchdog reload and routing block
// assumes the host model drives both access ports of the device
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
  import wdk_pkg::*;
  localparam logic [15:0] DEV = 16'h0A00;
  logic        mclk, nrst, io_valid, io_write, cfg_valid, cfg_write;
  logic        count_en, flag_clr, flag, smi;
  logic [15:0] io_addr, dev_base, irq;
  logic [7:0]  io_wdata, io_rdata, cfg_index, cfg_wdata, cfg_rdata;
  logic [23:0] init_value;
  int          failures, n_tests;

  wdk_host_model i_host (.i_mclk(mclk), .o_io_valid(io_valid),
    .o_io_write(io_write), .o_io_addr(io_addr), .o_io_wdata(io_wdata),
    .i_io_rdata(io_rdata), .o_cfg_valid(cfg_valid),
    .o_cfg_write(cfg_write), .o_cfg_index(cfg_index),
    .o_cfg_wdata(cfg_wdata), .i_cfg_rdata(cfg_rdata));

  // short tick keeps expiry runs brief
  wdk_top #(.P_TICK_CYC(4)) i_dut (.i_mclk(mclk), .i_nrst(nrst),
    .i_io_valid(io_valid), .i_io_write(io_write), .i_io_addr(io_addr),
    .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
    .i_cfg_valid(cfg_valid), .i_cfg_write(cfg_write),
    .i_cfg_index(cfg_index), .i_cfg_wdata(cfg_wdata),
    .o_cfg_rdata(cfg_rdata), .i_dev_base(dev_base),
    .i_init_value(init_value), .i_count_en(count_en),
    .i_flag_clr(flag_clr), .o_expiry_flag(flag), .o_irq(irq),
    .o_smi(smi));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    i_host.cfg_cycle(1'b1, idx, d, r);
  endtask : cfg_wr

  task automatic chk_cfg(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] r;
    i_host.cfg_cycle(1'b0, idx, 8'h00, r);
    `CHK(r, e)
  endtask : chk_cfg

  task automatic chk_count(input logic [23:0] e);
    logic [7:0] b0, b1, b2;
    i_host.io_cycle(1'b0, DEV, 8'h00, b0);
    i_host.io_cycle(1'b0, DEV + 16'h0001, 8'h00, b1);
    i_host.io_cycle(1'b0, DEV + 16'h0002, 8'h00, b2);
    `CHK({b2, b1, b0}, e)
  endtask : chk_count

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] ix [11] = '{8'h70, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5,
                            8'hF6, 8'h38, 8'h39, 8'h3A, 8'h00};
    logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    logic [7:0] fv [7]  = '{8'h0F, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                            8'hFF};
    for (int i = 0; i < 11; i++) chk_cfg(ix[i], rv[i]);
    for (int i = 0; i < 7; i++) cfg_wr(ix[i], 8'hFF);
    for (int i = 0; i < 7; i++) chk_cfg(ix[i], fv[i]);
    for (int i = 0; i < 7; i++) cfg_wr(ix[i], 8'h00);
    cfg_wr(8'hF3, 8'hA5);
    cfg_wr(8'hF4, 8'h5A);
    cfg_wr(8'hF6, 8'h3C);
    chk_cfg(8'hF2, 8'h00);
    chk_cfg(8'hF3, 8'hA5);
    chk_cfg(8'hF4, 8'h5A);
    chk_cfg(8'hF6, 8'h3C);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_reload();
    int          bt [5] = '{4, 3, 2, 1, 0};
    logic        wr [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0] hit [5] = '{16'h0080, 16'h0410, 16'h0410, 16'h0303,
                             16'h0300};
    logic [15:0] mis [5] = '{16'h0081, 16'h0411, 16'h0411, 16'h0304,
                             16'h0304};
    logic [7:0]  r;
    logic [7:0]  en;
    logic [23:0] k0, k1;
    cfg_wr(8'hF2, 8'h00);
    cfg_wr(8'hF3, 8'h03);
    cfg_wr(8'hF4, 8'h10);
    cfg_wr(8'hF5, 8'h04);
    cfg_wr(8'hF6, 8'h30);
    for (int i = 0; i < 5; i++) begin
      k0 = 24'h123450 + 24'(i);
      k1 = 24'hABC000 + 24'(i);
      en = 8'h01 << bt[i];
      @(posedge mclk);
      init_value <= k0;
      cfg_wr(8'h3A, 8'h00);
      chk_count(k0);
      @(posedge mclk);
      init_value <= k1;
      cfg_wr(8'hF1, 8'h1F & ~en);
      i_host.io_cycle(wr[i], hit[i], 8'h00, r);
      chk_count(k0);
      cfg_wr(8'hF1, en);
      i_host.io_cycle(wr[i], mis[i], 8'h00, r);
      chk_count(k0);
      i_host.io_cycle(wr[i], hit[i], 8'h00, r);
      chk_count(k1);
    end
    cfg_wr(8'hF1, 8'h00);
    $display("t_reload done");
  endtask : t_reload

  task automatic expire(input logic [3:0] code);
    logic [7:0] r;
    cfg_wr(8'h70, {4'h0, code});
    @(posedge mclk);
    init_value <= 24'h000002;
    count_en   <= 1'b1;
    i_host.io_cycle(1'b1, DEV + 16'h0001, 8'h00, r);
    for (int k = 0; k < 100 && flag !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    count_en <= 1'b0;
    #1 `CHK(flag, 1'b1)
  endtask : expire

  task automatic t_route();
    logic [15:0] e;
    logic [7:0]  r;
    for (int c = 0; c < 16; c++) begin
      expire(4'(c));
      e = (c inside {1, [3:7], [9:12]}) ? (16'h0001 << c) : 16'h0000;
      `CHK(irq, e)
      `CHK(smi, c == 2)
      @(posedge mclk);
      flag_clr <= 1'b1;
      @(posedge mclk);
      flag_clr <= 1'b0;
      @(posedge mclk);
      #1 `CHK(flag, 1'b0)
      `CHK(irq, 16'h0000)
    end
    // flag must be set first, or the clear below proves nothing
    expire(4'h3);
    cfg_wr(8'hF1, 8'h10);
    i_host.io_cycle(1'b1, POST_CODE_PORT, 8'h00, r);
    #1 `CHK(flag, 1'b0)
    `CHK(irq, 16'h0000)
    $display("t_route done");
  endtask : t_route

  task automatic wrap_up();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------------
  // clock, reset, sequence
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #300000;
    failures++;
    $display("unexpected at %0t: run hung", $time);
    wrap_up();
  end

  initial begin
    failures   = 0;
    n_tests    = 0;
    nrst       = 1'b0;
    count_en   = 1'b0;
    flag_clr   = 1'b0;
    dev_base   = DEV;
    init_value = 24'h000000;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_reload();
    t_route();
    wrap_up();
  end
endmodule : testbench

// >>> tb/wdk_host_model.sv
// host-side model: issues one-cycle i/o and configuration cycles
// assumes the device samples strobes on the rising edge of i_mclk
`timescale 1ns/10ps
module wdk_host_model (
  // clock
  input  wire logic        i_mclk,
  // i/o cycle toward the device
  output      logic        o_io_valid,
  output      logic        o_io_write,
  output      logic [15:0] o_io_addr,
  output      logic [7:0]  o_io_wdata,
  input  wire logic [7:0]  i_io_rdata,
  // configuration access toward the device
  output      logic        o_cfg_valid,
  output      logic        o_cfg_write,
  output      logic [7:0]  o_cfg_index,
  output      logic [7:0]  o_cfg_wdata,
  input  wire logic [7:0]  i_cfg_rdata
);
  initial begin
    o_io_valid  = 1'b0;
    o_io_write  = 1'b0;
    o_io_addr   = 16'h0000;
    o_io_wdata  = 8'h00;
    o_cfg_valid = 1'b0;
    o_cfg_write = 1'b0;
    o_cfg_index = 8'h00;
    o_cfg_wdata = 8'h00;
  end

  // released lines flip so a stale value never looks like a request
  task automatic io_cycle(input logic wr, input logic [15:0] a,
                          input logic [7:0] d, output logic [7:0] rd);
    @(posedge i_mclk);
    o_io_valid <= 1'b1;
    o_io_write <= wr;
    o_io_addr  <= a;
    o_io_wdata <= d;
    @(posedge i_mclk);
    o_io_valid <= 1'b0;
    o_io_write <= ~wr;
    o_io_addr  <= ~a;
    o_io_wdata <= ~d;
    #1 rd = i_io_rdata;
  endtask : io_cycle

  task automatic cfg_cycle(input logic wr, input logic [7:0] idx,
                           input logic [7:0] d, output logic [7:0] rd);
    @(posedge i_mclk);
    o_cfg_valid <= 1'b1;
    o_cfg_write <= wr;
    o_cfg_index <= idx;
    o_cfg_wdata <= d;
    @(posedge i_mclk);
    o_cfg_valid <= 1'b0;
    o_cfg_write <= ~wr;
    o_cfg_index <= ~idx;
    o_cfg_wdata <= ~d;
    #1 rd = i_cfg_rdata;
  endtask : cfg_cycle
endmodule : wdk_host_model

// >>> verilog/wdk_pkg.sv
// constants for the watchdog reload-source and routing block
// assumes one 200 MHz clock and a decoded host i/o cycle stream
package wdk_pkg;

  // ----------------------------------------------------------------
  // configuration indices
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_COUNT_LOW    = 8'h38;
  localparam logic [7:0]  IDX_COUNT_MID    = 8'h39;
  localparam logic [7:0]  IDX_COUNT_HIGH   = 8'h3A;
  localparam logic [7:0]  IDX_IRQ_ROUTING  = 8'h70;
  localparam logic [7:0]  IDX_RELOAD_EN    = 8'hF1;
  localparam logic [7:0]  IDX_WIN_A_LOW    = 8'hF2;
  localparam logic [7:0]  IDX_WIN_A_HIGH   = 8'hF3;
  localparam logic [7:0]  IDX_WIN_B_LOW    = 8'hF4;
  localparam logic [7:0]  IDX_WIN_B_HIGH   = 8'hF5;
  localparam logic [7:0]  IDX_WIN_MASKS    = 8'hF6;

  // ----------------------------------------------------------------
  // i/o offsets from the device base, and the absolute post code port
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_COUNT_LOW    = 16'h0000;
  localparam logic [15:0] OFS_COUNT_MID    = 16'h0001;
  localparam logic [15:0] OFS_COUNT_HIGH   = 16'h0002;
  localparam logic [15:0] POST_CODE_PORT   = 16'h0080;

  // ----------------------------------------------------------------
  // fields of the reload enable register
  // ----------------------------------------------------------------
  localparam int          BIT_WIN_A_RD     = 0;
  localparam int          BIT_WIN_A_WR     = 1;
  localparam int          BIT_WIN_B_RD     = 2;
  localparam int          BIT_WIN_B_WR     = 3;
  localparam int          BIT_POST_CODE    = 4;

  // ----------------------------------------------------------------
  // routing codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  ROUTE_OFF        = 4'h0;
  localparam logic [3:0]  ROUTE_SMI        = 4'h2;
  localparam logic [3:0]  ROUTE_IRQ8       = 4'h8;
  localparam logic [3:0]  ROUTE_LAST_IRQ   = 4'hC;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_ROUTING      = 4'h0;
  localparam logic [4:0]  RST_RELOAD_EN    = 5'h00;
  localparam logic [15:0] RST_WIN_BASE     = 16'h0000;
  localparam logic [7:0]  RST_WIN_MASKS    = 8'hFF;
  localparam logic [23:0] RST_COUNT        = 24'hFFFFFF;
  localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;

  // ----------------------------------------------------------------
  // timing: clock rate and the decrement rate
  // ----------------------------------------------------------------
  localparam int          CLK_HZ           = 200_000_000;
  localparam int          TICK_HZ          = 32_768;
  localparam int          TICK_CYC         = CLK_HZ / TICK_HZ;
  localparam int          TICK_W           = 13;

endpackage : wdk_pkg

// >>> verilog/wdk_top.sv
// watchdog down-counter with routing and reload-source logic
// assumes an upstream lpc decoder giving one-cycle i/o and config
// strobes on i_mclk; config-mode entry and the base register live
// outside, as do the initial value, status and control registers
//
// Behaviour
// - routing code zero: timeout raises neither irq nor smi
// - codes 1, 3..7 and 9..12 drive that irq line; code 2 drives smi
// - codes 8, 13, 14, 15 are disabled: no interrupt on timeout
// - write to port 80h reloads counter when enable bit 4 set
// - write into window b reloads counter when bit 3 set
// - read from window b reloads counter when bit 2 set
// - write into window a reloads counter when bit 1 set
// - read from window a reloads counter when bit 0 set
// - window a base, 16 bits read/write at indices f2h, f3h
// - window b base, 16 bits read/write at indices f4h, f5h
// - mask register f6h: window a mask in bits 7:4
// - mask register f6h: window b mask in bits 3:0
// - live count readable as bytes at base+0, +1, +2, low first
// - counter decrements at 32.768 khz, reloads from initial value
// - any write to the live count bytes reloads the counter
// - each window spans 1 to 16 bytes set by its mask
// - enabled port 80h or window reload also clears expiry flag
`timescale 1ns/10ps
module wdk_top #(
  parameter int P_TICK_CYC = wdk_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // host i/o cycle, one-cycle strobe
  input  wire logic        i_io_valid,
  input  wire logic        i_io_write,
  input  wire logic [15:0] i_io_addr,
  input  wire logic [7:0]  i_io_wdata,
  output      logic [7:0]  o_io_rdata,
  // configuration access, one-cycle strobe
  input  wire logic        i_cfg_valid,
  input  wire logic        i_cfg_write,
  input  wire logic [7:0]  i_cfg_index,
  input  wire logic [7:0]  i_cfg_wdata,
  output      logic [7:0]  o_cfg_rdata,
  // neighbouring registers
  input  wire logic [15:0] i_dev_base,
  input  wire logic [23:0] i_init_value,
  input  wire logic        i_count_en,
  input  wire logic        i_flag_clr,
  // timeout outputs
  output      logic        o_expiry_flag,
  output      logic [15:0] o_irq,
  output      logic        o_smi
);
  import wdk_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        route;
    logic [4:0]        reload_en;
    logic [15:0]       win_a_base;
    logic [15:0]       win_b_base;
    logic [7:0]        masks;
    logic [23:0]       count;
    logic [TICK_W-1:0] div;
    logic              flag;
    logic [15:0]       irq;
    logic              smi;
    logic [7:0]        cfg_rdata;
    logic [7:0]        io_rdata;
  } wdk_state_s;

  wdk_state_s st_ff;
  wdk_state_s nxt_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // masked compare
  // mask of 0..15 opens 1..16 bytes
  function automatic logic win_hit(input logic [15:0] addr,
                                   input logic [15:0] base,
                                   input logic [3:0]  mask);
    logic [15:0] care;
    care    = ~{12'h000, mask};
    win_hit = (addr & care) == (base & care);
  endfunction : win_hit

  function automatic logic route_is_irq(input logic [3:0] code);
    route_is_irq = (code != ROUTE_OFF) && (code != ROUTE_SMI) &&
                   (code != ROUTE_IRQ8) && (code <= ROUTE_LAST_IRQ);
  endfunction : route_is_irq

  function automatic logic [7:0] count_byte(input logic [23:0] cnt,
                                            input logic [1:0]  sel);
    count_byte = cnt[8*sel +: 8];
  endfunction : count_byte

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [15:0] io_ofs;
  logic        io_live;
  logic        hit_a;
  logic        hit_b;
  logic        win_reload;
  logic        live_reload;
  logic        tick;

  assign io_ofs  = i_io_addr - i_dev_base;
  assign io_live = i_io_valid && (io_ofs <= OFS_COUNT_HIGH);
  assign hit_a   = i_io_valid &&
                   win_hit(i_io_addr, st_ff.win_a_base, st_ff.masks[7:4]);
  assign hit_b   = i_io_valid &&
                   win_hit(i_io_addr, st_ff.win_b_base, st_ff.masks[3:0]);

  always_comb begin
    win_reload = 1'b0;
    if (i_io_valid && i_io_write && i_io_addr == POST_CODE_PORT &&
        st_ff.reload_en[BIT_POST_CODE]) begin
      win_reload = 1'b1;
    end
    if (hit_b && i_io_write && st_ff.reload_en[BIT_WIN_B_WR]) begin
      win_reload = 1'b1;
    end
    if (hit_b && !i_io_write && st_ff.reload_en[BIT_WIN_B_RD]) begin
      win_reload = 1'b1;
    end
    if (hit_a && i_io_write && st_ff.reload_en[BIT_WIN_A_WR]) begin
      win_reload = 1'b1;
    end
    if (hit_a && !i_io_write && st_ff.reload_en[BIT_WIN_A_RD]) begin
      win_reload = 1'b1;
    end
  end

  assign live_reload = (io_live && i_io_write) ||
                       (i_cfg_valid && i_cfg_write &&
                        (i_cfg_index == IDX_COUNT_LOW ||
                         i_cfg_index == IDX_COUNT_MID ||
                         i_cfg_index == IDX_COUNT_HIGH));

  // long divider kept as a parameter so simulation can shorten it
  assign tick = (st_ff.div == TICK_W'(P_TICK_CYC - 1));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    nxt_st.div = tick ? '0 : st_ff.div + TICK_W'(1);

    // configuration writes
    if (i_cfg_valid && i_cfg_write) begin
      unique case (i_cfg_index)
        IDX_IRQ_ROUTING: nxt_st.route = i_cfg_wdata[3:0];
        IDX_RELOAD_EN:   nxt_st.reload_en = i_cfg_wdata[4:0];
        IDX_WIN_A_LOW:   nxt_st.win_a_base[7:0] = i_cfg_wdata;
        IDX_WIN_A_HIGH:  nxt_st.win_a_base[15:8] = i_cfg_wdata;
        IDX_WIN_B_LOW:   nxt_st.win_b_base[7:0] = i_cfg_wdata;
        IDX_WIN_B_HIGH:  nxt_st.win_b_base[15:8] = i_cfg_wdata;
        IDX_WIN_MASKS:   nxt_st.masks = i_cfg_wdata;
        default: ;
      endcase
    end

    // clear first so that a same-cycle expiry wins below
    if (i_flag_clr) begin
      nxt_st.flag = 1'b0;
    end

    if (win_reload || live_reload) begin
      nxt_st.count = i_init_value;
      if (win_reload) begin
        nxt_st.flag = 1'b0;
      end
    end else if (tick && i_count_en && st_ff.count != '0) begin
      nxt_st.count = st_ff.count - 24'h000001;
      if (st_ff.count == 24'h000001) begin
        nxt_st.flag = 1'b1;
      end
    end

    nxt_st.irq = '0;
    nxt_st.smi = 1'b0;
    if (nxt_st.flag && route_is_irq(nxt_st.route)) begin
      nxt_st.irq[nxt_st.route] = 1'b1;
    end
    if (nxt_st.flag && nxt_st.route == ROUTE_SMI) begin
      nxt_st.smi = 1'b1;
    end

    // config read data, one cycle after the strobe
    if (i_cfg_valid && !i_cfg_write) begin
      unique case (i_cfg_index)
        IDX_COUNT_LOW:   nxt_st.cfg_rdata = count_byte(st_ff.count, 2'd0);
        IDX_COUNT_MID:   nxt_st.cfg_rdata = count_byte(st_ff.count, 2'd1);
        IDX_COUNT_HIGH:  nxt_st.cfg_rdata = count_byte(st_ff.count, 2'd2);
        IDX_IRQ_ROUTING: nxt_st.cfg_rdata = {4'h0, st_ff.route};
        IDX_RELOAD_EN:   nxt_st.cfg_rdata = {3'h0, st_ff.reload_en};
        IDX_WIN_A_LOW:   nxt_st.cfg_rdata = st_ff.win_a_base[7:0];
        IDX_WIN_A_HIGH:  nxt_st.cfg_rdata = st_ff.win_a_base[15:8];
        IDX_WIN_B_LOW:   nxt_st.cfg_rdata = st_ff.win_b_base[7:0];
        IDX_WIN_B_HIGH:  nxt_st.cfg_rdata = st_ff.win_b_base[15:8];
        IDX_WIN_MASKS:   nxt_st.cfg_rdata = st_ff.masks;
        default:         nxt_st.cfg_rdata = UNMAPPED_DATA;
      endcase
    end

    if (io_live && !i_io_write) begin
      nxt_st.io_rdata = count_byte(st_ff.count, io_ofs[1:0]);
    end else if (i_io_valid && !i_io_write) begin
      nxt_st.io_rdata = UNMAPPED_DATA;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_ff.route     <= RST_ROUTING;
      st_ff.reload_en <= RST_RELOAD_EN;
      st_ff.win_a_base <= RST_WIN_BASE;
      st_ff.win_b_base <= RST_WIN_BASE;
      st_ff.masks     <= RST_WIN_MASKS;
      st_ff.count     <= RST_COUNT;
      st_ff.div       <= '0;
      st_ff.flag      <= 1'b0;
      st_ff.irq       <= '0;
      st_ff.smi       <= 1'b0;
      st_ff.cfg_rdata <= UNMAPPED_DATA;
      st_ff.io_rdata  <= UNMAPPED_DATA;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_io_rdata    = st_ff.io_rdata;
  assign o_cfg_rdata   = st_ff.cfg_rdata;
  assign o_expiry_flag = st_ff.flag;
  assign o_irq         = st_ff.irq;
  assign o_smi         = st_ff.smi;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  property p_route_off;
    st_ff.route == ROUTE_OFF |-> (o_irq == '0) && !o_smi;
  endproperty
  a_route_off: assert property (p_route_off)
    else $error("routing off yet interrupt raised");

  property p_route_irq;
    o_expiry_flag && route_is_irq(st_ff.route) |->
      o_irq == (16'h0001 << st_ff.route) && !o_smi;
  endproperty
  a_route_irq: assert property (p_route_irq)
    else $error("timeout not on selected irq line");

  property p_route_disabled;
    (st_ff.route == ROUTE_IRQ8 || st_ff.route > ROUTE_LAST_IRQ) |->
      o_irq == '0 && !o_smi;
  endproperty
  a_route_disabled: assert property (p_route_disabled)
    else $error("disabled code raised an interrupt");

  property p_post_reload;
    i_io_valid && i_io_write && i_io_addr == POST_CODE_PORT &&
      st_ff.reload_en[BIT_POST_CODE] |=>
      st_ff.count == $past(i_init_value) && !o_expiry_flag;
  endproperty
  a_post_reload: assert property (p_post_reload)
    else $error("post code write did not reload");

  property p_win_b_wr_off;
    hit_b && i_io_write && !st_ff.reload_en[BIT_WIN_B_WR] &&
      !live_reload && !(i_io_addr == POST_CODE_PORT) &&
      !hit_a && !tick |=> st_ff.count == $past(st_ff.count);
  endproperty
  a_win_b_wr_off: assert property (p_win_b_wr_off)
    else $error("disabled window write changed counter");

  property p_win_a_rd;
    hit_a && !i_io_write && st_ff.reload_en[BIT_WIN_A_RD] |=>
      st_ff.count == $past(i_init_value);
  endproperty
  a_win_a_rd: assert property (p_win_a_rd)
    else $error("window read did not reload");

  property p_live_write;
    io_live && i_io_write |=> st_ff.count == $past(i_init_value);
  endproperty
  a_live_write: assert property (p_live_write)
    else $error("live count write did not reload");

  property p_expire;
    tick && i_count_en && st_ff.count == 24'h000001 &&
      !win_reload && !live_reload |=> o_expiry_flag ##1
      (o_expiry_flag || $past(i_flag_clr) || $past(win_reload));
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry flag not set at zero");

  property p_upper_zero;
    i_cfg_valid && !i_cfg_write && i_cfg_index == IDX_RELOAD_EN |=>
      o_cfg_rdata[7:5] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unused enable bits not zero");

  c_smi:     cover property (o_smi);
  c_irq:     cover property ($rose(o_expiry_flag) && o_irq != '0);
  c_win_rel: cover property (win_reload && o_expiry_flag);
  c_live:    cover property (io_live && i_io_write);

endmodule : wdk_top
